//--- hw/vam_pkg.sv
// Package for the virtual address mapper: register map, field positions,
// entry layouts and enumerations.
// Assumes 24-bit virtual and real addresses and a 32-bit APB.
package vam_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W   = 24;
  localparam int FRAME_W  = 13;
  localparam int STL_W    = 9;
  localparam int NEVT     = 3;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SEG_BASE = 8'h04;
  localparam logic [7:0] OFF_SEG_LEN  = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0C;
  localparam logic [7:0] OFF_INT_EN   = 8'h10;
  localparam logic [7:0] OFF_INT_CLR  = 8'h14;
  localparam logic [7:0] OFF_FAULT    = 8'h18;
  localparam logic [7:0] OFF_FT_IDX   = 8'h1C;
  localparam logic [7:0] OFF_FT_DATA  = 8'h20;
  localparam logic [7:0] OFF_RC_IDX   = 8'h24;
  localparam logic [7:0] OFF_RC_DATA  = 8'h28;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_FLAT   = 0;
  localparam int CTRL_SEG1M  = 1;
  localparam int CTRL_PG4K   = 2;
  localparam int EVT_SEGLEN  = 0;
  localparam int EVT_SEGINV  = 1;
  localparam int EVT_PAGE    = 2;
  localparam int FAULT_KIND  = 24;
  localparam int FT_VALID    = 31;
  localparam int RC_REF      = 0;
  localparam int RC_CHG      = 1;
  localparam int ENTRY_INV   = 0;
  localparam int PG2K_SHIFT  = 11;
  localparam int PG4K_SHIFT  = 12;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam logic [23:0] SEG_OFF_64K  = 24'h00FFFF;
  localparam logic [23:0] SEG_OFF_1M   = 24'h0FFFFF;
  localparam logic [23:0] WORD_MASK    = 24'hFFFFFC;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_ICOUNTER,
    KIND_IFETCH,
    KIND_OPERAND
  } vam_kind_t;

  typedef enum logic [2:0] {
    RSP_OK,
    RSP_SEGLEN,
    RSP_SEGINV,
    RSP_PAGE_XLATE,
    RSP_PAGE_ACCESS
  } vam_code_t;

endpackage

//--- hw/vam_flat_table.sv
// Single-level translation table kept in auxiliary storage.
// Assumes one write port from the register bus and two read ports.
module vam_flat_table #(
  parameter int IDX_W = 13
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Update port
  input  wire logic                       we,
  input  wire logic [IDX_W-1:0]           waddr,
  input  wire logic [vam_pkg::FRAME_W:0]  wdata,
  // Lookup port
  input  wire logic [IDX_W-1:0]           raddr_a,
  output logic      [vam_pkg::FRAME_W:0]  rdata_a,
  // Readback port
  input  wire logic [IDX_W-1:0]           raddr_b,
  output logic      [vam_pkg::FRAME_W:0]  rdata_b
);

  // Entry: top bit valid, low bits frame number
  logic [vam_pkg::FRAME_W:0] mem [2**IDX_W];
  logic [2**IDX_W-1:0]       vld;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vld <= '0;
    else if (we)
      vld[waddr] <= wdata[vam_pkg::FRAME_W];
  end

  always_ff @(posedge pclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Entries not yet written read as not assigned
  assign rdata_a = {vld[raddr_a], mem[raddr_a][vam_pkg::FRAME_W-1:0]};
  assign rdata_b = {vld[raddr_b], mem[raddr_b][vam_pkg::FRAME_W-1:0]};

endmodule

//--- hw/vam_refchg.sv
// Referenced and changed bits, one pair per 2K real frame.
// Assumes marks come from the translator and clears from the register bus.
module vam_refchg #(
  parameter int IDX_W = 13
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Mark port
  input  wire logic             mark,
  input  wire logic             mark_wr,
  input  wire logic [IDX_W-1:0] mark_frame,
  // Clear and read port
  input  wire logic             clr,
  input  wire logic [IDX_W-1:0] idx,
  output logic      [1:0]       rdata
);

  logic [2**IDX_W-1:0] refd;
  logic [2**IDX_W-1:0] chgd;
  logic                clr_ok;

  // A mark on the same frame wins over a clear
  assign clr_ok = clr && !(mark && mark_frame == idx);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refd <= '0;
      chgd <= '0;
    end
    else
    begin
      if (clr_ok)
      begin
        refd[idx] <= 1'b0;
        chgd[idx] <= 1'b0;
      end
      if (mark)
      begin
        refd[mark_frame] <= 1'b1;
        if (mark_wr)
          chgd[mark_frame] <= 1'b1;
      end
    end
  end

  assign rdata = {chgd[idx], refd[idx]};

endmodule

//--- hw/vam_top.sv
// Virtual address mapper: two-level table walk or flat table lookup.
// Assumes the core holds a request until rsp_valid and that table memory
// answers each mem_req with one mem_ack pulse.
//
// Operation
// - Two-level segments are 64K or 1M bytes on their own boundary.
// - One segment size applies to the whole virtual storage.
// - Every segment holds the same number of equal pages.
// - Two-level pages are 2K or 4K, aligned within the segment.
// - Flat mode has no segments; pages are always 2K.
// - Frames match page size; the page offset passes through unchanged.
// - Two-level walk uses one segment table and page tables in storage.
// - Segment table bounds the storage, marks segments, locates page tables.
// - Page entry gives residence and the frame address.
// - Non-resident page in a walk raises a page translation exception.
// - Flat mode maps through one table not addressable by programs.
// - Flat table changes only through dedicated page-handling writes.
// - Flat access to an unassigned page raises a page access exception.
// - Translation only while the status word bit is set; else real.
// - Instruction counter, fetch and operand addresses are all translated.
// - Referenced and changed state is recorded per page frame; kept per 2K unit, so a 4K page marks only the accessed half.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module vam_top #(
  parameter int FT_IDX_W = 13
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core request
  input  wire logic        program_status_word_xlate,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_kind,
  input  wire logic [23:0] req_vaddr,
  // Core answer
  output logic             rsp_valid,
  output logic             rsp_fault,
  output logic      [2:0]  rsp_code,
  output logic      [23:0] rsp_raddr,
  // Table memory
  output logic             mem_req,
  output logic      [23:0] mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // Interrupt
  output logic             irq
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEG,
    ST_PGREQ,
    ST_PAGE,
    ST_RESP
  } vam_state_t;

  // ----------------------------------------------------------------------
  // Index functions
  // ----------------------------------------------------------------------
  function automatic logic [23:0] seg_index(input logic [23:0] va, input logic seg1m);
    seg_index = seg1m ? (va >> 20) : (va >> 16);
  endfunction

  function automatic logic [23:0] page_index(input logic [23:0] va, input logic seg1m,
                                             input logic pg4k);
    logic [23:0] off;
    off = va & (seg1m ? vam_pkg::SEG_OFF_1M : vam_pkg::SEG_OFF_64K);
    page_index = pg4k ? (off >> vam_pkg::PG4K_SHIFT) : (off >> vam_pkg::PG2K_SHIFT);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  vam_state_t            state, next_state;
  logic [23:0]           va, next_va;
  logic                  wr, next_wr;
  logic [1:0]            kind, next_kind;
  logic [23:0]           pto, next_pto;
  logic                  next_mem_req;
  logic [23:0]           next_mem_addr;
  logic                  next_rsp_valid, next_rsp_fault;
  logic [2:0]            next_rsp_code;
  logic [23:0]           next_rsp_raddr;
  logic                  mark, next_mark;
  logic [vam_pkg::NEVT-1:0] evt, next_evt;
  logic [23:0]           fault_va, next_fault_va;
  logic [1:0]            fault_kind, next_fault_kind;

  logic [2:0]            ctrl, next_ctrl;
  logic [23:0]           sto, next_sto;
  logic [vam_pkg::STL_W-1:0] stl, next_stl;
  logic [vam_pkg::NEVT-1:0]  int_stat, next_int_stat;
  logic [vam_pkg::NEVT-1:0]  int_en, next_int_en;
  logic [FT_IDX_W-1:0]   ft_idx, next_ft_idx;
  logic [FT_IDX_W-1:0]   rc_idx, next_rc_idx;
  logic [31:0]           next_prdata;
  logic                  next_pready, next_pslverr, next_irq;

  logic                  ft_we, rc_clr, commit;
  logic [vam_pkg::FRAME_W:0] ft_rd_a, ft_rd_b;
  logic [1:0]            rc_rd;
  logic [23:0]           seg_i;

  assign seg_i = seg_index(req_vaddr, ctrl[vam_pkg::CTRL_SEG1M]);

  // ----------------------------------------------------------------------
  // Translation sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_va         = va;
    next_wr         = wr;
    next_kind       = kind;
    next_pto        = pto;
    next_mem_req    = mem_req;
    next_mem_addr   = mem_addr;
    next_rsp_valid  = 1'b0;
    next_rsp_fault  = rsp_fault;
    next_rsp_code   = rsp_code;
    next_rsp_raddr  = rsp_raddr;
    next_mark       = 1'b0;
    next_evt        = '0;
    next_fault_va   = fault_va;
    next_fault_kind = fault_kind;
    case (state)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          // Every access kind goes the same way
          next_va   = req_vaddr;
          next_wr   = req_write;
          next_kind = req_kind;
          next_rsp_fault = 1'b0;
          next_rsp_code  = vam_pkg::RSP_OK;
          next_state     = ST_RESP;
          next_rsp_valid = 1'b1;
          if (!program_status_word_xlate)
            next_rsp_raddr = req_vaddr;
          else if (ctrl[vam_pkg::CTRL_FLAT])
          begin
            if (!ft_rd_a[vam_pkg::FRAME_W])
            begin
              // Lookup has no segment level and a fixed 2K page
              next_rsp_fault = 1'b1;
              next_rsp_code  = vam_pkg::RSP_PAGE_ACCESS;
              next_rsp_raddr = '0;
              next_evt[vam_pkg::EVT_PAGE] = 1'b1;
              next_fault_va   = req_vaddr;
              next_fault_kind = req_kind;
            end
            else
            begin
              next_rsp_raddr = {ft_rd_a[vam_pkg::FRAME_W-1:0], req_vaddr[10:0]};
              next_mark = 1'b1;
            end
          end
          else if (seg_i >= 24'(stl))
          begin
            next_rsp_fault = 1'b1;
            next_rsp_code  = vam_pkg::RSP_SEGLEN;
            next_rsp_raddr = '0;
            next_evt[vam_pkg::EVT_SEGLEN] = 1'b1;
            next_fault_va   = req_vaddr;
            next_fault_kind = req_kind;
          end
          else
          begin
            next_rsp_valid = 1'b0;
            next_mem_req   = 1'b1;
            next_mem_addr  = sto + (seg_i << 2);
            next_state     = ST_SEG;
          end
        end
      end
      ST_SEG:
      begin
        if (mem_ack)
        begin
          next_mem_req = 1'b0;
          if (mem_rdata[vam_pkg::ENTRY_INV])
          begin
            next_rsp_fault  = 1'b1;
            next_rsp_code   = vam_pkg::RSP_SEGINV;
            next_rsp_raddr  = '0;
            next_evt[vam_pkg::EVT_SEGINV] = 1'b1;
            next_fault_va   = va;
            next_fault_kind = kind;
            next_rsp_valid  = 1'b1;
            next_state      = ST_RESP;
          end
          else
          begin
            next_pto   = mem_rdata[23:0] & vam_pkg::WORD_MASK;
            next_state = ST_PGREQ;
          end
        end
      end
      ST_PGREQ:
      begin
        next_mem_req  = 1'b1;
        next_mem_addr = pto + (page_index(va, ctrl[vam_pkg::CTRL_SEG1M],
                                          ctrl[vam_pkg::CTRL_PG4K]) << 2);
        next_state    = ST_PAGE;
      end
      ST_PAGE:
      begin
        if (mem_ack)
        begin
          next_mem_req   = 1'b0;
          next_rsp_valid = 1'b1;
          next_state     = ST_RESP;
          if (mem_rdata[vam_pkg::ENTRY_INV])
          begin
            next_rsp_fault  = 1'b1;
            next_rsp_code   = vam_pkg::RSP_PAGE_XLATE;
            next_rsp_raddr  = '0;
            next_evt[vam_pkg::EVT_PAGE] = 1'b1;
            next_fault_va   = va;
            next_fault_kind = kind;
          end
          else if (ctrl[vam_pkg::CTRL_PG4K])
          begin
            next_rsp_raddr = {mem_rdata[23:12], va[11:0]};
            next_mark      = 1'b1;
          end
          else
          begin
            next_rsp_raddr = {mem_rdata[23:11], va[10:0]};
            next_mark      = 1'b1;
          end
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= ST_IDLE;
      va         <= '0;
      wr         <= 1'b0;
      kind       <= '0;
      pto        <= '0;
      mem_req    <= 1'b0;
      mem_addr   <= '0;
      rsp_valid  <= 1'b0;
      rsp_fault  <= 1'b0;
      rsp_code   <= '0;
      rsp_raddr  <= '0;
      mark       <= 1'b0;
      evt        <= '0;
      fault_va   <= '0;
      fault_kind <= '0;
    end
    else
    begin
      state      <= next_state;
      va         <= next_va;
      wr         <= next_wr;
      kind       <= next_kind;
      pto        <= next_pto;
      mem_req    <= next_mem_req;
      mem_addr   <= next_mem_addr;
      rsp_valid  <= next_rsp_valid;
      rsp_fault  <= next_rsp_fault;
      rsp_code   <= next_rsp_code;
      rsp_raddr  <= next_rsp_raddr;
      mark       <= next_mark;
      evt        <= next_evt;
      fault_va   <= next_fault_va;
      fault_kind <= next_fault_kind;
    end
  end

  // ----------------------------------------------------------------------
  // APB registers and interrupt
  // ----------------------------------------------------------------------
  // One wait state: data and error are registered on the same edge as pready rises
  assign commit = psel && penable && pready;
  assign ft_we  = commit && pwrite && paddr == vam_pkg::OFF_FT_DATA;
  assign rc_clr = commit && pwrite && paddr == vam_pkg::OFF_RC_DATA;

  always_comb
  begin
    next_ctrl     = ctrl;
    next_sto      = sto;
    next_stl      = stl;
    next_int_en   = int_en;
    next_ft_idx   = ft_idx;
    next_rc_idx   = rc_idx;
    next_int_stat = int_stat;
    next_prdata   = prdata;
    next_pslverr  = 1'b0;
    next_pready   = psel && penable && !pready;
    if (commit && pwrite)
    begin
      if (paddr == vam_pkg::OFF_CTRL)
        next_ctrl = pwdata[2:0];
      else if (paddr == vam_pkg::OFF_SEG_BASE)
        next_sto = pwdata[23:0] & vam_pkg::WORD_MASK;
      else if (paddr == vam_pkg::OFF_SEG_LEN)
        next_stl = pwdata[vam_pkg::STL_W-1:0];
      else if (paddr == vam_pkg::OFF_INT_EN)
        next_int_en = pwdata[vam_pkg::NEVT-1:0];
      else if (paddr == vam_pkg::OFF_INT_CLR)
        next_int_stat = int_stat & ~pwdata[vam_pkg::NEVT-1:0];
      else if (paddr == vam_pkg::OFF_FT_IDX)
        next_ft_idx = pwdata[FT_IDX_W-1:0];
      else if (paddr == vam_pkg::OFF_RC_IDX)
        next_rc_idx = pwdata[FT_IDX_W-1:0];
    end
    // Events set after the clear so a coincident event is kept
    next_int_stat = next_int_stat | evt;
    if (psel && penable && !pready)
    begin
      next_prdata = '0;
      if (paddr == vam_pkg::OFF_CTRL)
        next_prdata[2:0] = ctrl;
      else if (paddr == vam_pkg::OFF_SEG_BASE)
        next_prdata[23:0] = sto;
      else if (paddr == vam_pkg::OFF_SEG_LEN)
        next_prdata[vam_pkg::STL_W-1:0] = stl;
      else if (paddr == vam_pkg::OFF_INT_STAT)
        next_prdata[vam_pkg::NEVT-1:0] = int_stat;
      else if (paddr == vam_pkg::OFF_INT_EN)
        next_prdata[vam_pkg::NEVT-1:0] = int_en;
      else if (paddr == vam_pkg::OFF_INT_CLR)
        next_prdata = '0;
      else if (paddr == vam_pkg::OFF_FAULT)
        next_prdata = {6'h00, fault_kind, fault_va};
      else if (paddr == vam_pkg::OFF_FT_IDX)
        next_prdata[FT_IDX_W-1:0] = ft_idx;
      else if (paddr == vam_pkg::OFF_FT_DATA)
      begin
        next_prdata[vam_pkg::FT_VALID] = ft_rd_b[vam_pkg::FRAME_W];
        next_prdata[vam_pkg::FRAME_W-1:0] = ft_rd_b[vam_pkg::FRAME_W-1:0];
      end
      else if (paddr == vam_pkg::OFF_RC_IDX)
        next_prdata[FT_IDX_W-1:0] = rc_idx;
      else if (paddr == vam_pkg::OFF_RC_DATA)
        next_prdata[1:0] = rc_rd;
      else
        next_pslverr = 1'b1;
    end
    next_irq = |(next_int_stat & next_int_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl     <= vam_pkg::CTRL_RST;
      sto      <= '0;
      stl      <= '0;
      int_stat <= '0;
      int_en   <= '0;
      ft_idx   <= '0;
      rc_idx   <= '0;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      ctrl     <= next_ctrl;
      sto      <= next_sto;
      stl      <= next_stl;
      int_stat <= next_int_stat;
      int_en   <= next_int_en;
      ft_idx   <= next_ft_idx;
      rc_idx   <= next_rc_idx;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      irq      <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Tables
  // ----------------------------------------------------------------------
  vam_flat_table #(
    .IDX_W (FT_IDX_W)
  ) u_flat (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (ft_we),
    .waddr   (ft_idx),
    .wdata   ({pwdata[vam_pkg::FT_VALID], pwdata[vam_pkg::FRAME_W-1:0]}),
    .raddr_a (req_vaddr[vam_pkg::PG2K_SHIFT +: FT_IDX_W]),
    .rdata_a (ft_rd_a),
    .raddr_b (ft_idx),
    .rdata_b (ft_rd_b)
  );

  // Frame number kept in 2K units; a 4K frame marks the half holding the accessed address
  vam_refchg #(
    .IDX_W (FT_IDX_W)
  ) u_refchg (
    .pclk       (pclk),
    .presetn    (presetn),
    .mark       (mark),
    .mark_wr    (wr),
    .mark_frame (rsp_raddr[vam_pkg::PG2K_SHIFT +: FT_IDX_W]),
    .clr        (rc_clr),
    .idx        (rc_idx),
    .rdata      (rc_rd)
  );

endmodule

//--- verification/vam_props.sv
// Checker for the mapper's core, table and APB handshake ports.
// Assumes it is bound to vam_top and sees only its ports.
module vam_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Core side
  input wire logic        program_status_word_xlate,
  input wire logic        req_valid,
  input wire logic [23:0] req_vaddr,
  input wire logic        rsp_valid,
  input wire logic        rsp_fault,
  input wire logic [2:0]  rsp_code,
  input wire logic [23:0] rsp_raddr,
  // Table memory
  input wire logic        mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic        mem_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  chk_offset_pass: assert property (
    rsp_valid && !rsp_fault |-> rsp_raddr[10:0] == req_vaddr[10:0])
    else $error("page offset altered");
  chk_real_mode: assert property (
    $rose(req_valid) && !program_status_word_xlate |=>
      rsp_valid && !rsp_fault && rsp_raddr == $past(req_vaddr))
    else $error("real mode address not passed through");
  chk_fault_zero: assert property (
    rsp_valid && rsp_fault |-> rsp_raddr == 24'h0 && rsp_code != 3'h0)
    else $error("fault answer carries an address");
  chk_code_match: assert property (
    rsp_valid |-> (rsp_code == 3'h0) == !rsp_fault)
    else $error("fault flag and code disagree");
  chk_ack_drop: assert property (
    mem_ack |=> !mem_req)
    else $error("table read kept after answer");
  chk_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("table read dropped early");
  chk_word_addr: assert property (
    mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("table entry address not word aligned");
  chk_rsp_bound: assert property (
    $rose(req_valid) |-> ##[1:40] rsp_valid)
    else $error("request not answered");
  chk_rsp_pulse: assert property (
    rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  chk_apb_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("register access not answered");
endmodule

//--- verification/vam_mem.sv
// Table memory model holding segment and page tables for the mapper.
// Assumes each mem_req is held until its mem_ack pulse.
module vam_mem (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Table read port
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  // Wait states before each answer
  input  wire logic [1:0]  wait_n
);
  // ----------------------------------------------------------------------
  // Storage and answer timing
  // ----------------------------------------------------------------------
  logic [31:0] mem [512];
  logic [1:0]  cnt;

  initial
  begin
    foreach (mem[i]) mem[i] = 32'h1;
  end

  // Inverse data outside the answer so a late sample cannot pass by luck
  assign mem_rdata = mem_ack ? mem[mem_addr[10:2]] : ~mem[mem_addr[10:2]];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt     <= 2'h0;
      mem_ack <= 1'b0;
    end
    else
    begin
      mem_ack <= mem_req && !mem_ack && cnt == wait_n;
      cnt     <= (mem_req && !mem_ack && cnt != wait_n) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule

//--- verification/tb.sv
// Testbench for the mapper: APB register and core request sequences.
// Assumes vam_mem stands for table storage and vam_props is bound below.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic        program_status_word_xlate, req_valid, req_write;
  logic        rsp_valid, rsp_fault, mem_req, mem_ack;
  logic [1:0]  req_kind, wait_n;
  logic [2:0]  rsp_code;
  logic [7:0]  paddr;
  logic [23:0] req_vaddr, rsp_raddr, mem_addr;
  logic [31:0] pwdata, prdata, mem_rdata, r;
  int          n_mismatch, num_checks;

  vam_top #(.FT_IDX_W(6)) dut (.*);
  vam_mem u_mem (.*);

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rv, output logic ev);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
    chk("write error", e, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk("read data", r, x);
  endtask

  task automatic xl(input logic [23:0] va, input logic [1:0] k, input logic w,
                    input logic [2:0] code, input logic [23:0] ra);
    int n;
    req_vaddr <= va;
    req_kind  <= k;
    req_write <= w;
    req_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 60);
    chk("answer", rsp_valid, 1'b1);
    chk("code", rsp_code, code);
    chk("fault", rsp_fault, code != 3'h0);
    chk("real address", rsp_raddr, ra);
    req_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    {psel, penable, pwrite, req_valid, req_write, program_status_word_xlate} = '0;
    paddr = 8'h0;
    pwdata = 32'h0;
    req_kind = 2'h0;
    req_vaddr = 24'h0;
    wait_n = 2'h0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    u_mem.mem[0] = 32'h100;
    u_mem.mem[9'h40] = 32'h91800;
    u_mem.mem[9'h130] = 32'hA000;
    @(posedge pclk);
    rd(vam_pkg::OFF_CTRL, 32'h0);
    rd(vam_pkg::OFF_INT_STAT, 32'h0);
    apb(1'b0, 8'hFC, 32'h0, r, e);
    chk("unmapped error", e, 1'b1);
    for (int k = 0; k < 3; k++) xl(24'h123456, k[1:0], 1'b0, 3'h0, 24'h123456);
    $display("test real mode done");
    program_status_word_xlate <= 1'b1;
    wr(vam_pkg::OFF_SEG_LEN, 32'h2);
    wr(vam_pkg::OFF_INT_EN, 32'h4);
    for (int k = 0; k < 3; k++)
    begin
      wait_n <= 2'(3 * k);
      xl(24'h000234, k[1:0], 1'b0, 3'h0, 24'h091A34);
    end
    wr(vam_pkg::OFF_RC_IDX, 32'h123);
    rd(vam_pkg::OFF_RC_DATA, 32'h1);
    xl(24'h000834, 2'h2, 1'b0, 3'h3, 24'h0);
    rd(vam_pkg::OFF_INT_STAT, 32'h4);
    rd(vam_pkg::OFF_FAULT, 32'h02000834);
    chk("irq", irq, 1'b1);
    wr(vam_pkg::OFF_INT_CLR, 32'h4);
    @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    wr(vam_pkg::OFF_INT_EN, 32'h0);
    xl(24'h010000, 2'h1, 1'b0, 3'h2, 24'h0);
    xl(24'h020000, 2'h0, 1'b0, 3'h1, 24'h0);
    rd(vam_pkg::OFF_INT_STAT, 32'h3);
    chk("irq masked", irq, 1'b0);
    $display("test two-level done");
    wr(vam_pkg::OFF_CTRL, 32'h6);
    xl(24'h000834, 2'h2, 1'b0, 3'h0, 24'h091834);
    xl(24'h0F0834, 2'h1, 1'b0, 3'h0, 24'h00A834);
    wr(vam_pkg::OFF_CTRL, 32'h2);
    xl(24'h000834, 2'h2, 1'b0, 3'h3, 24'h0);
    wr(vam_pkg::OFF_CTRL, 32'h4);
    xl(24'h000834, 2'h2, 1'b0, 3'h0, 24'h091834);
    xl(24'h0F0834, 2'h0, 1'b0, 3'h1, 24'h0);
    $display("test large sizes done");
    wr(vam_pkg::OFF_CTRL, 32'h1);
    wr(vam_pkg::OFF_FT_IDX, 32'h1);
    wr(vam_pkg::OFF_FT_DATA, 32'h80000055);
    rd(vam_pkg::OFF_FT_DATA, 32'h80000055);
    xl(24'h000834, 2'h2, 1'b1, 3'h0, 24'h02A834);
    xl(24'h000100, 2'h1, 1'b0, 3'h4, 24'h0);
    wr(vam_pkg::OFF_RC_IDX, 32'h55);
    rd(vam_pkg::OFF_RC_DATA, 32'h3);
    wr(vam_pkg::OFF_RC_DATA, 32'h0);
    rd(vam_pkg::OFF_RC_DATA, 32'h0);
    $display("test flat mode done");
    test_done();
  end
endmodule

bind vam_top vam_props u_props (.*);
